// >>> hdl/capture_port_consts.svh
// constants of the waveform capture serial port
`ifndef CAPTURE_PORT_CONSTS_SVH
`define CAPTURE_PORT_CONSTS_SVH

// ************************************************
// field positions
// ************************************************
`define CAP_GENCFG_ENABLE_BIT 6
`define CAP_SETUP_CLK_BIT     0
`define CAP_SETUP_SIZE_BIT    1
`define CAP_SETUP_GAP_BIT     2
`define CAP_SETUP_SET_LO      3
`define CAP_SETUP_SET_HI      4
`define CAP_SETUP_POL_BIT     5
`define CAP_SETUP_RESET       8'h00

// ************************************************
// word slots and sets
// ************************************************
`define CAP_SLOT_NEUTRAL      6
`define CAP_SLOT_POWER_FIRST  7
`define CAP_SLOT_VAR_FIRST    13
`define CAP_SLOT_LAST         15
`define CAP_SET_WAVES         2'h1
`define CAP_SET_POWERS        2'h2

// ************************************************
// timing
// ************************************************
`define CAP_REF_PERIOD_PS     10000
`define CAP_FAST_PERIOD_PS    125000
`define CAP_SLOW_PERIOD_PS    250000
`define CAP_GAP_CYCLES        7

`endif

// >>> hdl/capture_port_pkg.sv
// types of the waveform capture serial port
package capture_port_pkg;

  // transfer sequencer states
  typedef enum logic [1:0] {
    CAP_IDLE,
    CAP_SHIFT,
    CAP_GAP,
    CAP_END
  } cap_state_t;

  // whole state of the capture port
  typedef struct packed {
    cap_state_t        state;     // sequencer
    logic              sclk;      // serial clock level
    logic              sdo;       // serial data level
    logic              sel;       // select level
    logic              enable;    // general config enable bit
    logic [7:0]        setup;     // setup register as written
    logic [5:0]        xCfg;      // setup latched per transfer
    logic [15:0][23:0] words;     // latched sample set
    logic [3:0]        wordIdx;   // slot being sent
    logic [3:0]        lastIdx;   // final slot of transfer
    logic [4:0]        bitCnt;    // bit within word, msb first
    logic [4:0]        gapCnt;    // half periods spent in gap
    logic              busy;      // transfer in progress
  } cap_state_all_t;

endpackage

// >>> hdl/clock_tick_gen.sv
// half-period tick divider for the capture serial clock
`timescale 1ns/1ps
`include "capture_port_consts.svh"

module clock_tick_gen #(
  parameter int FAST_HALF = ((`CAP_FAST_PERIOD_PS / 2)
                            + `CAP_REF_PERIOD_PS - 1)
                            / `CAP_REF_PERIOD_PS,
  parameter int SLOW_HALF = ((`CAP_SLOW_PERIOD_PS / 2)
                            + `CAP_REF_PERIOD_PS - 1)
                            / `CAP_REF_PERIOD_PS
) (
  input  wire logic ref_clk,  // system clock
  input  wire logic reset,    // async reset, active high
  input  wire logic run,      // count while high
  input  wire logic slow,     // 1 selects the slower rate
  output logic      tick      // one-cycle pulse per half period
);

  // half periods round up so the link never runs above its rate
  logic [7:0] count_q;  // cycles into current half period
  logic [7:0] limit;    // last count of a half period

  // ************************************************
  // divider
  // ************************************************
  // rate choice
  always_comb begin
    limit = slow ? 8'(SLOW_HALF - 1) : 8'(FAST_HALF - 1);
  end

  // restarts on every run so the first tick is a full half period
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      count_q <= 8'h00;
      tick    <= 1'b0;
    end else if (!run) begin
      count_q <= 8'h00;
      tick    <= 1'b0;
    end else if (count_q >= limit) begin
      count_q <= 8'h00;
      tick    <= 1'b1;
    end else begin
      count_q <= count_q + 8'h01;
      tick    <= 1'b0;
    end
  end

endmodule // clock_tick_gen

// >>> hdl/capture_port.sv
// waveform capture serial port: streams sample words as a master
`timescale 1ns/1ps
`include "capture_port_consts.svh"

module capture_port #(
  parameter bit HAS_NEUTRAL  = 1'b1,  // neutral current present
  parameter bit HAS_REACTIVE = 1'b1   // reactive powers present
) (
  input  wire logic ref_clk,                    // 100 MHz clock
  input  wire logic reset,                      // async, active high
  input  wire logic hostIsI2c,                  // host port is I2C
  input  wire logic genCfgWrEn,                 // general config write
  input  wire logic [7:0] genCfgWrData,         // general config data
  input  wire logic setupWrEn,                  // setup write strobe
  input  wire logic [7:0] setupWrData,          // setup write data
  input  wire logic sampleStrobe,               // new samples ready
  input  wire logic [15:0][23:0] sampleWords,   // slot-ordered values
  output logic [7:0] setupRdData,               // setup readback
  output logic      captureEnabled,             // stored enable bit
  output logic      transferBusy,               // transfer running
  output logic      capture_clock_out,          // serial clock
  output logic      capture_data_out,           // serial data
  output logic      capture_select_out          // select line
);
  import capture_port_pkg::*;

  // ************************************************
  // declarations
  // ************************************************
  cap_state_all_t st_q;     // registered state
  cap_state_all_t st_d;     // next state
  logic           tick;     // half-period pulse
  logic           runDiv;   // divider runs during transfers
  logic           portOn;   // enable qualified by host mode
  logic           activeLv; // select level inside a package
  logic           idleLv;   // select level outside packages
  logic [31:0]    curWord;  // word now being shifted
  logic           lastBit;  // current bit closes its word
  logic           pkgEnd;   // current bit closes a package
  logic [1:0]     wordSet;  // latched word set selection

  // ************************************************
  // helpers
  // ************************************************
  // slot to outgoing word; absent registers read as zero
  function automatic logic [31:0] slotWord(
    input logic [15:0][23:0] w,
    input logic [3:0]        idx
  );
    logic [23:0] v;
    v = w[idx];
    if (!HAS_NEUTRAL && idx == 4'(`CAP_SLOT_NEUTRAL)) begin
      v = 24'h000000;
    end
    if (!HAS_REACTIVE && idx >= 4'(`CAP_SLOT_VAR_FIRST)) begin
      v = 24'h000000;
    end
    // sign extension to the link width
    slotWord = {{8{v[23]}}, v};
  endfunction

  // first slot of a word set
  function automatic logic [3:0] setFirst(input logic [1:0] s);
    setFirst = (s == `CAP_SET_POWERS)
             ? 4'(`CAP_SLOT_POWER_FIRST) : 4'h0;
  endfunction

  // last slot of a word set; 11 falls back to the full set
  function automatic logic [3:0] setLast(input logic [1:0] s);
    if (s == `CAP_SET_WAVES) begin
      setLast = 4'(`CAP_SLOT_NEUTRAL);
    end else begin
      setLast = 4'(`CAP_SLOT_LAST);
    end
  endfunction

  // ************************************************
  // rate divider
  // ************************************************
  // only runs while a transfer is out, so the clock idles
  assign runDiv = (st_q.state != CAP_IDLE);

  clock_tick_gen u_tick (
    .ref_clk (ref_clk),
    .reset   (reset),
    .run     (runDiv),
    .slow    (st_q.xCfg[`CAP_SETUP_CLK_BIT]),
    .tick    (tick)
  );

  // ************************************************
  // decode
  // ************************************************
  // qualified enable and package framing
  always_comb begin
    // spi host mode masks the enable bit
    portOn   = st_q.enable & hostIsI2c;
    // select level inside packages
    activeLv = st_q.xCfg[`CAP_SETUP_POL_BIT];
    // idle level follows the live setup value
    idleLv   = ~st_q.setup[`CAP_SETUP_POL_BIT];
    wordSet  = st_q.xCfg[`CAP_SETUP_SET_HI:`CAP_SETUP_SET_LO];
    // slots follow the fixed word order of the sample set
    curWord  = slotWord(st_q.words, st_q.wordIdx);
    lastBit  = (st_q.bitCnt == 5'h1f);
    // byte packages only matter with gaps
    if (st_q.xCfg[`CAP_SETUP_GAP_BIT]
        && st_q.xCfg[`CAP_SETUP_SIZE_BIT]) begin
      pkgEnd = (st_q.bitCnt[2:0] == 3'h7);
    end else begin
      pkgEnd = lastBit;
    end
  end

  // ************************************************
  // next state
  // ************************************************
  // all sequencing and register writes in one place
  always_comb begin
    st_d      = st_q;
    st_d.busy = (st_q.state != CAP_IDLE);

    // register writes; reserved setup bits are kept but unused
    if (genCfgWrEn) begin
      st_d.enable = genCfgWrData[`CAP_GENCFG_ENABLE_BIT];
    end
    if (setupWrEn) begin
      st_d.setup = setupWrData;
    end

    case (st_q.state)
      // waiting for a sample strobe
      CAP_IDLE: begin
        st_d.sclk = 1'b1;  // clock idles high
        st_d.sdo  = 1'b1;  // data idles high
        st_d.sel  = idleLv;
        // one start per strobe; strobes while busy are lost,
        // so long transfers fall to every other sample
        if (portOn && sampleStrobe) begin
          st_d.words   = sampleWords;
          // bits 7:6 never reach the sequencer
          st_d.xCfg    = st_q.setup[5:0];
          st_d.wordIdx = setFirst(
            st_q.setup[`CAP_SETUP_SET_HI:`CAP_SETUP_SET_LO]);
          st_d.lastIdx = setLast(
            st_q.setup[`CAP_SETUP_SET_HI:`CAP_SETUP_SET_LO]);
          st_d.bitCnt  = 5'h00;
          st_d.gapCnt  = 5'h00;
          st_d.sel     = st_q.setup[`CAP_SETUP_POL_BIT];
          st_d.state   = CAP_SHIFT;
          st_d.busy    = 1'b1;
        end
      end

      // shifting bits of a package
      CAP_SHIFT: begin
        if (tick) begin
          if (st_q.sclk) begin
            // falling edge: launch next bit msb first
            st_d.sclk = 1'b0;
            st_d.sdo  = curWord[5'd31 - st_q.bitCnt];
          end else begin
            // rising edge: the slave samples here
            st_d.sclk = 1'b1;
            st_d.bitCnt = st_q.bitCnt + 5'h01;
            if (lastBit) begin
              st_d.wordIdx = st_q.wordIdx + 4'h1;
            end
            if (lastBit && st_q.wordIdx == st_q.lastIdx) begin
              // whole set sent
              st_d.state = CAP_END;
            end else if (pkgEnd
                         && st_q.xCfg[`CAP_SETUP_GAP_BIT]) begin
              // idle clocks between packages
              st_d.gapCnt = 5'h00;
              st_d.state  = CAP_GAP;
            end
            // no gap: the next fall carries on
          end
        end
      end

      // idle clocks between packages, select released
      CAP_GAP: begin
        if (tick) begin
          st_d.sel    = ~activeLv;
          st_d.gapCnt = st_q.gapCnt + 5'h01;
          // two half periods per idle clock
          if (st_q.gapCnt == 5'(2 * `CAP_GAP_CYCLES - 1)) begin
            st_d.sel   = activeLv;
            st_d.state = CAP_SHIFT;
          end
        end
      end

      // release select half a period after the final rise
      CAP_END: begin
        if (tick) begin
          st_d.sel   = idleLv;
          st_d.sdo   = 1'b1;
          st_d.state = CAP_IDLE;
        end
      end

      default: begin
        st_d.state = CAP_IDLE;
      end
    endcase

    // losing the enable aborts at once; pins return to idle
    if (!portOn && st_q.state != CAP_IDLE) begin
      st_d.state = CAP_IDLE;
      st_d.sclk  = 1'b1;
      st_d.sdo   = 1'b1;
      st_d.sel   = idleLv;
      st_d.busy  = 1'b0;
    end
  end

  // ************************************************
  // state register
  // ************************************************
  // reset leaves the port off with data and select high
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      st_q         <= '0;
      st_q.state   <= CAP_IDLE;
      st_q.sclk    <= 1'b1;
      st_q.sdo     <= 1'b1;
      st_q.sel     <= 1'b1;
      st_q.enable  <= 1'b0;
      st_q.setup   <= `CAP_SETUP_RESET;
    end else begin
      st_q <= st_d;
    end
  end

  // ************************************************
  // outputs
  // ************************************************
  // each output is a field of the state register
  // the port is always master and drives all three
  assign capture_clock_out  = st_q.sclk;
  assign capture_data_out   = st_q.sdo;
  assign capture_select_out = st_q.sel;
  assign setupRdData        = st_q.setup;
  assign transferBusy       = st_q.busy;
  assign captureEnabled     = st_q.enable;

endmodule // capture_port

// >>> bench/capture_port_asserts.sv
// assertion checker for the capture serial port
`timescale 1ns/1ps

module capture_port_asserts (
  input wire logic       ref_clk,            // system clock
  input wire logic       reset,              // async reset
  input wire logic       hostIsI2c,          // host port is I2C
  input wire logic       genCfgWrEn,         // general config write
  input wire logic [7:0] genCfgWrData,       // general config data
  input wire logic       setupWrEn,          // setup write strobe
  input wire logic [7:0] setupWrData,        // setup write data
  input wire logic       sampleStrobe,       // new samples ready
  input wire logic [7:0] setupRdData,        // setup readback
  input wire logic       captureEnabled,     // stored enable
  input wire logic       transferBusy,       // transfer running
  input wire logic       capture_clock_out,  // serial clock
  input wire logic       capture_data_out,   // serial data
  input wire logic       capture_select_out  // select line
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);

  // ************************************************
  // register echo and start
  // ************************************************
  a_setup_echo: assert property (setupWrEn |=>
    setupRdData == $past(setupWrData)) else $error("setup echo wrong");
  a_enable_echo: assert property (genCfgWrEn |=>
    captureEnabled == $past(genCfgWrData[6])) else $error("enable wrong");
  a_no_start_off: assert property (sampleStrobe && !transferBusy &&
    !(captureEnabled && hostIsI2c) |=> !transferBusy)
    else $error("transfer started while off");
  a_start_select: assert property (sampleStrobe && !transferBusy &&
    captureEnabled && hostIsI2c |=> transferBusy &&
    capture_select_out == $past(setupRdData[5]))
    else $error("start or select level wrong");

  // ************************************************
  // line levels and timing
  // ************************************************
  a_idle_lines: assert property (!transferBusy |->
    capture_clock_out && capture_data_out) else $error("idle not high");
  // select idles at the inverse of the polarity bit, after it settled
  a_idle_select: assert property (!transferBusy &&
    $past(!transferBusy) && setupRdData == $past(setupRdData, 2) |->
    capture_select_out == !setupRdData[5]) else $error("idle select");
  a_data_at_fall: assert property ($changed(capture_data_out) &&
    !capture_data_out |-> $fell(capture_clock_out))
    else $error("data fell off clock fall");
  // an abort may cut a half period short, so disabled while off
  a_data_hold: assert property (disable iff (reset || !captureEnabled ||
    !hostIsI2c) $rose(capture_clock_out) |-> $stable(capture_data_out))
    else $error("data moved at rise");
  a_clk_low_half: assert property (disable iff (reset ||
    !captureEnabled || !hostIsI2c) $fell(capture_clock_out) |->
    !capture_clock_out [*7] ##[1:7] capture_clock_out)
    else $error("low half period wrong");
  a_clk_high_half: assert property (disable iff (reset ||
    !captureEnabled || !hostIsI2c) $rose(capture_clock_out) |->
    capture_clock_out [*7]) else $error("high half too short");

  c_start: cover property ($rose(transferBusy));
  c_gap: cover property (transferBusy && $changed(capture_select_out));
  c_end: cover property ($fell(transferBusy));
endmodule // capture_port_asserts

bind capture_port capture_port_asserts u_capture_port_asserts (
  .ref_clk, .reset, .hostIsI2c, .genCfgWrEn, .genCfgWrData, .setupWrEn,
  .setupWrData, .sampleStrobe, .setupRdData, .captureEnabled,
  .transferBusy, .capture_clock_out, .capture_data_out,
  .capture_select_out);

// >>> bench/capture_rx.sv
// receiving serial slave model for the capture port
`timescale 1ns/1ps

module capture_rx (
  input wire logic sclk,  // serial clock from the port
  input wire logic sel,   // select line
  input wire logic sdo,   // serial data line
  input wire logic pol    // select level while a package runs
);
  logic bits[$];  // bits taken, oldest first
  int   pkts = 0; // packages seen
  // take a bit on each rising clock inside a package
  always @(posedge sclk) begin
    if (sel === pol) begin
      bits.push_back(sdo);
    end
  end
  // count each start of a package
  always @(sel) begin
    if (sel === pol) begin
      pkts++;
    end
  end
endmodule // capture_rx

// >>> bench/tb.sv
// self-checking bench of the capture serial port
`timescale 1ns/1ps
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin \
  err_total++; $display("[ERR] %s exp %h got %h", n, e, g); end end

module tb;
  logic              ref_clk = 1'b0;       // 100 MHz clock
  logic              reset = 1'b1;         // async reset
  logic              hostIsI2c = 1'b1;     // host port mode
  logic              genCfgWrEn = 1'b0;    // general config write
  logic [7:0]        genCfgWrData = 8'h00; // general config data
  logic              setupWrEn = 1'b0;     // setup write
  logic [7:0]        setupWrData = 8'h00;  // setup data
  logic              sampleStrobe = 1'b0;  // sample strobe
  logic [15:0][23:0] sampleWords = '0;     // words to the port
  logic [15:0][23:0] words;                // reference sample set
  logic [7:0]        setupRdData;          // setup readback
  logic              captureEnabled;       // stored enable
  logic              transferBusy;         // transfer running
  logic              sclk, sdo, sel;       // serial lines
  logic              pol = 1'b0;           // expected active select
  int                err_total = 0;        // mismatches
  int                checks_done = 0;      // comparisons

  always #5 ref_clk = ~ref_clk;

  capture_port u_capture_port (.ref_clk, .reset, .hostIsI2c, .genCfgWrEn,
    .genCfgWrData, .setupWrEn, .setupWrData, .sampleStrobe, .sampleWords,
    .setupRdData, .captureEnabled, .transferBusy,
    .capture_clock_out(sclk), .capture_data_out(sdo),
    .capture_select_out(sel));
  capture_rx u_capture_rx (.sclk(sclk), .sel(sel), .sdo(sdo), .pol(pol));

  // ************************************************
  // access tasks
  // ************************************************
  task automatic tick();
    @(posedge ref_clk);
    #1;
  endtask
  // one-cycle register write, general config when gen is set
  task automatic wr(input logic gen, input logic [7:0] v);
    tick();
    genCfgWrEn = gen;
    genCfgWrData = v;
    setupWrEn = !gen;
    setupWrData = v;
    tick();
    genCfgWrEn = 1'b0;
    setupWrEn = 1'b0;
  endtask
  task automatic strobe();
    tick();
    sampleStrobe = 1'b1;
    tick();
    sampleStrobe = 1'b0;
  endtask
  task automatic complete_run();
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // one transfer of slots lo..hi, pk packages expected
  task automatic xfer(input logic [7:0] cfg, input int lo, input int hi,
                      input int pk);
    logic [31:0] w;
    int          n;
    n = 0;
    pol = cfg[5];
    wr(1'b0, cfg);
    `CHK("setup readback", cfg, setupRdData)
    u_capture_rx.bits.delete();
    u_capture_rx.pkts = 0;
    sampleWords = words;
    strobe();
    sampleWords = '0; // later changes must not reach the frame
    repeat (200) tick();
    strobe(); // dropped: the port is still busy
    while (transferBusy === 1'b1 && n < 20000) begin
      tick();
      n++;
    end
    if (n >= 20000) begin
      err_total++;
      complete_run();
    end
    `CHK("bit count", (hi - lo + 1) * 32, u_capture_rx.bits.size())
    `CHK("packages", pk, u_capture_rx.pkts)
    for (int s = lo; s <= hi; s++) begin
      w = {{8{words[s][23]}}, words[s]};
      for (int b = 31; b >= 0; b--) begin
        `CHK("bit", w[b], u_capture_rx.bits[(s - lo) * 32 + 31 - b])
      end
    end
  endtask

  // ************************************************
  // main sequence
  // ************************************************
  initial begin
    for (int i = 0; i < 16; i++) begin
      words[i] = 24'h9a5c30 ^ 24'(i * 24'h111111);
    end
    repeat (4) @(posedge ref_clk);
    #1 reset = 1'b0;
    `CHK("setup reset", 8'h00, setupRdData)
    `CHK("idle lines", 3'b111, {sclk, sdo, sel})
    `CHK("enable reset", 1'b0, captureEnabled)
    strobe();
    tick();
    `CHK("busy when off", 1'b0, transferBusy)
    wr(1'b0, 8'h00);
    wr(1'b1, 8'h40);
    hostIsI2c = 1'b0;
    strobe();
    tick();
    `CHK("busy host spi", 1'b0, transferBusy)
    hostIsI2c = 1'b1;
    `CHK("enable set", 1'b1, captureEnabled)
    xfer(8'h00, 0, 15, 1);
    xfer(8'hee, 0, 6, 28);
    xfer(8'h15, 7, 15, 9);
    xfer(8'h18, 0, 15, 1);
    complete_run();
  end
endmodule // tb
